//--- core/indirect_host_register_port.sv
// Byte-wide host port with indirect access to the internal register space
// Behaviour
// - Host picks one of eight byte registers
// - Internal space: 12-bit address, 32-bit data
// - Upper address register bits 3:0 hold top
// - Lower address register holds low eight bits
// - Read-increment bit advances address after reads
// - Write-increment bit advances address after writes
// - Both bits set: advance after every access
// - Writing byte 0 starts internal write
// - Reading byte 0 starts read, loads bytes
// - Internal access takes exactly two clocks
// - Sleep and sync registers act immediately
// - Sync register: types fan to selected channels
// - Program bits permit channel memory loading
// - Sleep bits activate channels, high runs
// - Start sync clears channel sleep bit
// - Separate strobes: ready low until internal done
// - Data strobe: acknowledge low until strobe released
// - Ready/acknowledge pin is open drain
// - Many accesses under one chip select
`timescale 1ns/10ps
`default_nettype none
module indirect_host_register_port (
  input  wire logic                           clk_sys,
  input  wire logic                           resetn,
  input  wire logic                           mode_strap,
  input  wire logic                           chip_select_n,
  input  wire logic                           data_strobe_n,
  input  wire logic                           write_strobe_rw,
  input  wire logic [host_port_pkg::XA_W-1:0] host_addr,
  input  wire logic [host_port_pkg::XD_W-1:0] host_data_in,
  output logic      [host_port_pkg::XD_W-1:0] host_data_out,
  output logic                                host_data_oe_n,
  output logic                                access_acknowledge_n,
  output logic                                access_acknowledge_oe_n,
  output logic                                int_wr_en,
  output logic                                int_rd_en,
  output logic      [host_port_pkg::IA_W-1:0] int_addr,
  output logic      [host_port_pkg::ID_W-1:0] int_wdata,
  input  wire logic [host_port_pkg::ID_W-1:0] int_rdata,
  input  wire logic [host_port_pkg::CH_N-1:0] pin_start_sync,
  output logic      [host_port_pkg::CH_N-1:0] channel_awake,
  output logic      [host_port_pkg::CH_N-1:0] channel_program_en,
  output logic      [host_port_pkg::CH_N-1:0] beam_sync,
  output logic      [host_port_pkg::CH_N-1:0] hop_sync,
  output logic      [host_port_pkg::CH_N-1:0] start_sync
);
  localparam int PIN_W = 5 + host_port_pkg::XA_W + host_port_pkg::XD_W;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_HOLD = 2'b10
  } port_state_t;

  typedef struct packed {
    port_state_t                    st;
    logic                           mode;
    logic                           mode_taken;
    logic                           is_wr;
    logic [host_port_pkg::XD_W-1:0] b0;
    logic [host_port_pkg::XD_W-1:0] b1;
    logic [host_port_pkg::XD_W-1:0] b2;
    logic [host_port_pkg::XD_W-1:0] b3;
    logic [host_port_pkg::IA_W-1:0] ia;
    logic                           wrinc;
    logic                           rdinc;
    logic [host_port_pkg::CH_N-1:0] prog;
    logic [host_port_pkg::CH_N-1:0] sleep;
    logic [host_port_pkg::CH_N-1:0] beam;
    logic [host_port_pkg::CH_N-1:0] hop;
    logic [host_port_pkg::CH_N-1:0] start;
    logic [host_port_pkg::XD_W-1:0] dout;
    logic                           go;
    logic                           go_wr;
  } port_reg_t;

  port_reg_t r;
  port_reg_t r_nxt;

  logic [PIN_W-1:0]                 pins_s;
  logic                             fill_s;
  logic                             cs_s;
  logic                             ds_s;
  logic                             wrl_s;
  logic                             mode_s;
  logic [host_port_pkg::XA_W-1:0]   xa_s;
  logic [host_port_pkg::XD_W-1:0]   xd_s;
  logic                             act;
  logic                             wr_req;
  logic [host_port_pkg::CH_N-1:0]   sel;

  int_access_if acc ();

  pin_sync #(.W(PIN_W)) u_pin_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .pin_in  ({1'b1, mode_strap, !chip_select_n, !data_strobe_n, !write_strobe_rw,
               host_addr, host_data_in}),
    .pin_out (pins_s)
  );

  // Strobes inverted so cleared stages read idle; top bit marks filled stages
  assign {fill_s, mode_s, cs_s, ds_s, wrl_s, xa_s, xd_s} = pins_s;

  // Mode 0: read strobe and write strobe; mode 1: data strobe and read/write
  always_comb begin
    if (r.mode) begin
      act    = cs_s && ds_s;
      wr_req = wrl_s;
    end else begin
      act    = cs_s && (ds_s || wrl_s);
      wr_req = wrl_s;
    end
  end

  assign sel = xd_s[host_port_pkg::SYNC_SEL_MSB:host_port_pkg::SYNC_SEL_LSB];

  always_comb begin
    r_nxt       = r;
    r_nxt.go    = 1'b0;
    r_nxt.beam  = '0;
    r_nxt.hop   = '0;
    r_nxt.start = '0;
    if (!r.mode_taken && fill_s) begin
      r_nxt.mode       = mode_s;
      r_nxt.mode_taken = 1'b1;
    end
    case (r.st)
      ST_IDLE: begin
        if (act && r.mode_taken) begin
          r_nxt.is_wr = wr_req;
          r_nxt.st    = ST_HOLD;
          if (wr_req) begin
            case (xa_s)
              host_port_pkg::OFS_DATA_BYTE_0: begin
                r_nxt.b0    = xd_s;
                r_nxt.go    = 1'b1;
                r_nxt.go_wr = 1'b1;
                r_nxt.st    = ST_BUSY;
              end
              host_port_pkg::OFS_DATA_BYTE_1: r_nxt.b1 = xd_s;
              host_port_pkg::OFS_DATA_BYTE_2: r_nxt.b2 = xd_s;
              host_port_pkg::OFS_DATA_BYTE_3: r_nxt.b3 = xd_s;
              host_port_pkg::OFS_SLEEP: begin
                r_nxt.prog  = xd_s[host_port_pkg::PROG_MSB:host_port_pkg::PROG_LSB];
                r_nxt.sleep = xd_s[host_port_pkg::SLEEP_MSB:host_port_pkg::SLEEP_LSB];
              end
              host_port_pkg::OFS_SYNC: begin
                r_nxt.beam  = sel & {host_port_pkg::CH_N{xd_s[host_port_pkg::SYNC_BEAM]}};
                r_nxt.hop   = sel & {host_port_pkg::CH_N{xd_s[host_port_pkg::SYNC_HOP]}};
                r_nxt.start = sel & {host_port_pkg::CH_N{xd_s[host_port_pkg::SYNC_START]}};
              end
              host_port_pkg::OFS_LOW: r_nxt.ia[7:0] = xd_s;
              host_port_pkg::OFS_HIGH: begin
                r_nxt.wrinc = xd_s[host_port_pkg::HIGH_WRINC];
                r_nxt.rdinc = xd_s[host_port_pkg::HIGH_RDINC];
                r_nxt.ia[host_port_pkg::IA_W-1:8] =
                  xd_s[host_port_pkg::HIGH_IA_MSB:host_port_pkg::HIGH_IA_LSB];
              end
              default: r_nxt.st = ST_HOLD;
            endcase
          end else begin
            case (xa_s)
              host_port_pkg::OFS_DATA_BYTE_0: begin
                r_nxt.go    = 1'b1;
                r_nxt.go_wr = 1'b0;
                r_nxt.st    = ST_BUSY;
              end
              host_port_pkg::OFS_DATA_BYTE_1: r_nxt.dout = r.b1;
              host_port_pkg::OFS_DATA_BYTE_2: r_nxt.dout = r.b2;
              host_port_pkg::OFS_DATA_BYTE_3: r_nxt.dout = r.b3;
              host_port_pkg::OFS_SLEEP: r_nxt.dout = {r.prog, r.sleep};
              host_port_pkg::OFS_SYNC:  r_nxt.dout = host_port_pkg::SYNC_READ;
              host_port_pkg::OFS_LOW:   r_nxt.dout = r.ia[7:0];
              host_port_pkg::OFS_HIGH:
                r_nxt.dout = {r.wrinc, r.rdinc, host_port_pkg::HIGH_GAP,
                              r.ia[host_port_pkg::IA_W-1:8]};
              default: r_nxt.dout = '0;
            endcase
          end
        end
      end
      ST_BUSY: begin
        if (acc.done) begin
          r_nxt.st = ST_HOLD;
          if (!r.is_wr) begin
            {r_nxt.b3, r_nxt.b2, r_nxt.b1, r_nxt.b0} = acc.rdata;
            r_nxt.dout = acc.rdata[host_port_pkg::XD_W-1:0];
          end
          if ((r.is_wr && r.wrinc) ||
              (!r.is_wr && r.rdinc)) begin
            r_nxt.ia = r.ia + host_port_pkg::IA_STEP;
          end
        end
      end
      ST_HOLD: begin
        if (!act) begin
          r_nxt.st = ST_IDLE;
        end
      end
      default: r_nxt.st = ST_IDLE;
    endcase
    // Start sync from software or pin puts the channel to sleep
    r_nxt.sleep = r_nxt.sleep & ~(r_nxt.start | pin_start_sync);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign acc.start    = r.go;
  assign acc.is_write = r.go_wr;
  assign acc.addr     = r.ia;
  assign acc.wdata    = {r.b3, r.b2, r.b1, r.b0};

  int_access_seq u_seq (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .req       (acc.seq),
    .int_wr_en (int_wr_en),
    .int_rd_en (int_rd_en),
    .int_addr  (int_addr),
    .int_wdata (int_wdata),
    .int_rdata (int_rdata)
  );

  // Open-drain handshake: pin only ever pulled low
  assign access_acknowledge_n = 1'b0;
  always_comb begin
    if (r.mode) begin
      access_acknowledge_oe_n = !((r.st == ST_HOLD) && act);
    end else begin
      access_acknowledge_oe_n = !((r.st == ST_BUSY) ||
        ((r.st == ST_IDLE) && act && r.mode_taken));
    end
  end

  assign host_data_out      = r.dout;
  assign host_data_oe_n     = !((r.st == ST_HOLD) && act && !r.is_wr);
  assign channel_awake      = r.sleep;
  assign channel_program_en = r.prog;
  assign beam_sync          = r.beam;
  assign hop_sync           = r.hop;
  assign start_sync         = r.start;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_access_two_cycles: assert property (acc.start |-> ##2 acc.done)
    else $error("internal access did not finish in two cycles");
  a_strobe_length: assert property (acc.start |=> (int_wr_en || int_rd_en) [*2] ##1
    !(int_wr_en || int_rd_en))
    else $error("internal strobe not two cycles long");
  a_write_starts: assert property ((r.st == ST_IDLE) && act && r.mode_taken && wr_req &&
    (xa_s == host_port_pkg::OFS_DATA_BYTE_0) |=> acc.start && acc.is_write)
    else $error("write to byte 0 did not start internal write");
  a_read_loads: assert property ((r.st == ST_BUSY) && acc.done && !r.is_wr |=>
    ({r.b3, r.b2, r.b1, r.b0} == $past(acc.rdata)) && (host_data_out == r.b0))
    else $error("internal read did not load data bytes");
  a_addr_inc: assert property ((r.st == ST_BUSY) && acc.done &&
    ((r.is_wr && r.wrinc) || (!r.is_wr && r.rdinc)) |=>
    r.ia == $past(r.ia) + host_port_pkg::IA_STEP)
    else $error("address not advanced after access");
  a_addr_hold: assert property ((r.st == ST_BUSY) && acc.done &&
    !((r.is_wr && r.wrinc) || (!r.is_wr && r.rdinc)) |=> $stable(r.ia))
    else $error("address changed without increment enabled");
  a_wr_noinc: assert property ((r.st == ST_BUSY) && acc.done && r.is_wr && !r.wrinc |=>
    $stable(r.ia))
    else $error("write advanced address with increment off");
  a_ready_busy: assert property (!r.mode && acc.start |-> !access_acknowledge_oe_n [*2])
    else $error("ready not held low during internal access");
  a_ack_release: assert property (r.mode && (r.st == ST_HOLD) && !act |->
    access_acknowledge_oe_n ##1 (r.st == ST_IDLE))
    else $error("acknowledge held after strobe release");
  a_sync_fanout: assert property ((r.st == ST_IDLE) && act && r.mode_taken && wr_req &&
    (xa_s == host_port_pkg::OFS_SYNC) |=>
    hop_sync == ($past(sel) & {host_port_pkg::CH_N{$past(xd_s[host_port_pkg::SYNC_HOP])}}))
    else $error("hop sync not sent to selected channels");
  a_start_sleeps: assert property ((start_sync & channel_awake) == '0)
    else $error("channel awake after start sync");
  a_high_gap: assert property ((r.st == ST_IDLE) && act && r.mode_taken && !wr_req &&
    (xa_s == host_port_pkg::OFS_HIGH) |=> host_data_out[5:4] == host_port_pkg::HIGH_GAP)
    else $error("unused upper address bits read nonzero");

  c_int_write: cover property (acc.start && acc.is_write ##2 acc.done);
  c_int_read: cover property (acc.start && !acc.is_write ##2 acc.done);
  c_ack_mode1: cover property (r.mode && !access_acknowledge_oe_n);
  c_ready_mode0: cover property (!r.mode && r.mode_taken && !access_acknowledge_oe_n);
  c_sleep_clear: cover property ((start_sync & $past(channel_awake)) != '0);
endmodule
`default_nettype wire

//--- core/host_port_pkg.sv
// Constants shared by the indirect host register port
package host_port_pkg;

  // External register offsets on the 3-bit host address
  localparam logic [2:0] OFS_DATA_BYTE_0 = 3'h0;
  localparam logic [2:0] OFS_DATA_BYTE_1 = 3'h1;
  localparam logic [2:0] OFS_DATA_BYTE_2 = 3'h2;
  localparam logic [2:0] OFS_DATA_BYTE_3 = 3'h3;
  localparam logic [2:0] OFS_SLEEP = 3'h4;
  localparam logic [2:0] OFS_SYNC  = 3'h5;
  localparam logic [2:0] OFS_LOW   = 3'h6;
  localparam logic [2:0] OFS_HIGH  = 3'h7;

  // Widths
  localparam int XA_W = 3;
  localparam int XD_W = 8;
  localparam int IA_W = 12;
  localparam int ID_W = 32;
  localparam int CH_N = 4;

  // Upper address register fields
  localparam int HIGH_WRINC = 7;
  localparam int HIGH_RDINC = 6;
  localparam int HIGH_IA_MSB = 3;
  localparam int HIGH_IA_LSB = 0;

  // Software sync register fields
  localparam int SYNC_BEAM = 6;
  localparam int SYNC_HOP  = 5;
  localparam int SYNC_START = 4;
  localparam int SYNC_SEL_MSB = 3;
  localparam int SYNC_SEL_LSB = 0;

  // Sleep/program register fields
  localparam int PROG_MSB  = 7;
  localparam int PROG_LSB  = 4;
  localparam int SLEEP_MSB = 3;
  localparam int SLEEP_LSB = 0;

  // Values
  localparam logic [IA_W-1:0] IA_STEP   = 12'h001;
  localparam logic [1:0]      HIGH_GAP  = 2'h0;
  localparam logic [XD_W-1:0] SYNC_READ = 8'h00;

  // Timing: device clock period in ns and internal access length in device clocks
  localparam int CLK_PERIOD_NS = 40;
  localparam int ACCESS_CYCLES = 2;
  localparam logic [0:0] ACC_LAST = 1'(ACCESS_CYCLES - 1);

endpackage

//--- core/int_access_if.sv
// Request and answer between the host port and its internal access sequencer
`timescale 1ns/10ps
`default_nettype none
interface int_access_if;
  logic                         start;
  logic                         is_write;
  logic [host_port_pkg::IA_W-1:0] addr;
  logic [host_port_pkg::ID_W-1:0] wdata;
  logic [host_port_pkg::ID_W-1:0] rdata;
  logic                         done;
  modport port (output start, output is_write, output addr, output wdata,
                input rdata, input done);
  modport seq  (input start, input is_write, input addr, input wdata,
                output rdata, output done);
endinterface
`default_nettype wire

//--- core/pin_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t r;
  sync_state_t r_nxt;

  always_comb begin
    r_nxt        = r;
    r_nxt.meta   = pin_in;
    r_nxt.stable = r.meta;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign pin_out = r.stable;
endmodule
`default_nettype wire

//--- core/int_access_seq.sv
// Sequencer that runs one fixed-length internal register access
`timescale 1ns/10ps
`default_nettype none
module int_access_seq (
  input  wire logic                           clk_sys,
  input  wire logic                           resetn,
  int_access_if.seq                           req,
  output logic                                int_wr_en,
  output logic                                int_rd_en,
  output logic [host_port_pkg::IA_W-1:0]      int_addr,
  output logic [host_port_pkg::ID_W-1:0]      int_wdata,
  input  wire logic [host_port_pkg::ID_W-1:0] int_rdata
);
  typedef struct packed {
    logic                           busy;
    logic                           is_write;
    logic [0:0]                     cnt;
    logic [host_port_pkg::IA_W-1:0] addr;
    logic [host_port_pkg::ID_W-1:0] wdata;
    logic [host_port_pkg::ID_W-1:0] rdata;
  } seq_state_t;

  seq_state_t r;
  seq_state_t r_nxt;
  logic       last;

  assign last = r.busy && (r.cnt == host_port_pkg::ACC_LAST);

  always_comb begin
    r_nxt = r;
    if (r.busy) begin
      r_nxt.cnt = r.cnt + 1'b1;
      if (last) begin
        r_nxt.busy = 1'b0;
        if (!r.is_write) begin
          r_nxt.rdata = int_rdata;
        end
      end
    end else if (req.start) begin
      r_nxt.busy     = 1'b1;
      r_nxt.cnt      = '0;
      r_nxt.is_write = req.is_write;
      r_nxt.addr     = req.addr;
      r_nxt.wdata    = req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  // Two-cycle strobe on the internal bus
  assign int_wr_en = r.busy && r.is_write;
  assign int_rd_en = r.busy && !r.is_write;
  assign int_addr  = r.addr;
  assign int_wdata = r.wdata;
  assign req.done  = last;
  assign req.rdata = int_rdata;
endmodule
`default_nettype wire

//--- verification/host_cpu_model.sv
// Host processor model driving the byte-wide register port
`timescale 1ns/10ps
`default_nettype none
module host_cpu_model (
  input  wire logic       clk_sys,
  input  wire logic       mode,
  output logic            cs_n,
  output logic            strobe_n,
  output logic            wr_rw,
  output logic      [2:0] addr,
  output wire logic [7:0] bus,
  input  wire logic [7:0] dev_q,
  input  wire logic       dev_oe_n,
  input  wire logic       rdy_n,
  input  wire logic       rdy_oe_n
);
  logic      [7:0] wdata;
  logic      [7:0] last;
  logic            drive;
  wire logic       rdy = rdy_oe_n ? 1'b1 : rdy_n;

  // Released bus shows the inverse of its last level
  assign bus = !dev_oe_n ? dev_q : (drive ? wdata : ~last);

  always @(posedge clk_sys) begin
    if (drive || !dev_oe_n) last <= (^bus === 1'bx) ? 8'h00 : bus;
  end

  initial begin
    cs_n     = 1'b1;
    strobe_n = 1'b1;
    wr_rw    = 1'b1;
    addr     = 3'h0;
    wdata    = 8'h00;
    drive    = 1'b0;
    last     = 8'h00;
  end

  // One byte access; hold keeps the strobe that many extra cycles
  task automatic xfer(input logic is_wr, input logic [2:0] a, input logic [7:0] d,
                      input int hold, output logic [7:0] q, output logic ok);
    int n;
    ok = 1'b1;
    @(posedge clk_sys);
    cs_n     <= 1'b0;
    addr     <= a;
    wdata    <= d;
    drive    <= is_wr;
    wr_rw    <= !is_wr;
    strobe_n <= mode ? 1'b0 : is_wr;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rdy !== 1'b0 && n < 40);
    if (!mode) begin
      ok = (n < 40);
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (rdy !== 1'b1 && n < 40);
    end
    if (n >= 40) ok = 1'b0;
    q = bus;
    repeat (hold) begin
      @(posedge clk_sys);
      if (mode && rdy !== 1'b0) ok = 1'b0;
    end
    strobe_n <= 1'b1;
    wr_rw    <= 1'b1;
    drive    <= 1'b0;
    repeat (4) @(posedge clk_sys);
    if (rdy !== 1'b1) ok = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verification/test_indirect_host_register_port.sv
// Self-checking bench for the indirect host register port
`timescale 1ns/10ps
`default_nettype none
module test_indirect_host_register_port;
  logic            clk_sys;
  logic            resetn;
  logic            mode_strap;
  wire logic       cs_n;
  wire logic       ds_n;
  wire logic       wr_rw;
  wire logic [2:0] haddr;
  wire logic [7:0] hbus;
  logic      [7:0] dq;
  logic            doe_n;
  logic            ack_n;
  logic            ack_oe_n;
  logic            wr_en;
  logic            rd_en;
  logic     [11:0] iaddr;
  logic     [31:0] iwdata;
  logic      [3:0] pin_ss;
  logic      [3:0] awake;
  logic      [3:0] prog;
  logic      [3:0] beam;
  logic      [3:0] hop;
  logic      [3:0] ss;
  logic     [31:0] mem [0:4095];
  logic     [11:0] wa_q[$];
  logic     [31:0] wd_q[$];
  int              pulse_n[3][4];
  int              run_len;
  int              error_cnt;
  int              check_count;
  logic      [7:0] q;

  indirect_host_register_port i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .mode_strap(mode_strap), .chip_select_n(cs_n),
    .data_strobe_n(ds_n), .write_strobe_rw(wr_rw), .host_addr(haddr),
    .host_data_in(hbus), .host_data_out(dq), .host_data_oe_n(doe_n),
    .access_acknowledge_n(ack_n), .access_acknowledge_oe_n(ack_oe_n),
    .int_wr_en(wr_en), .int_rd_en(rd_en), .int_addr(iaddr), .int_wdata(iwdata),
    .int_rdata(mem[iaddr]), .pin_start_sync(pin_ss), .channel_awake(awake),
    .channel_program_en(prog), .beam_sync(beam), .hop_sync(hop), .start_sync(ss));

  host_cpu_model i_host (
    .clk_sys(clk_sys), .mode(mode_strap), .cs_n(cs_n), .strobe_n(ds_n), .wr_rw(wr_rw),
    .addr(haddr), .bus(hbus), .dev_q(dq), .dev_oe_n(doe_n), .rdy_n(ack_n),
    .rdy_oe_n(ack_oe_n));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic conclude;
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Internal register space, strobe length and sync pulse counts
  always @(posedge clk_sys) begin
    if (wr_en === 1'b1 && run_len == 0) begin
      wa_q.push_back(iaddr);
      wd_q.push_back(iwdata);
    end
    if (wr_en === 1'b1 || rd_en === 1'b1) begin
      run_len <= run_len + 1;
    end else begin
      if (run_len != 0) check(run_len, host_port_pkg::ACCESS_CYCLES, "strobe length");
      run_len <= 0;
    end
    if (wr_en === 1'b1) mem[iaddr] <= iwdata;
    for (int c = 0; c < 4; c++) begin
      pulse_n[0][c] <= pulse_n[0][c] + int'(beam[c] === 1'b1);
      pulse_n[1][c] <= pulse_n[1][c] + int'(hop[c] === 1'b1);
      pulse_n[2][c] <= pulse_n[2][c] + int'(ss[c] === 1'b1);
    end
    if (ack_oe_n === 1'b0) check(32'(ack_n), 32'h0, "ready pin level");
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic ok;
    i_host.xfer(1'b1, a, d, 0, q, ok);
    check(32'(ok), 32'h1, "write handshake");
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string msg);
    logic ok;
    i_host.xfer(1'b0, a, 8'h00, 2, q, ok);
    check(32'(ok), 32'h1, "read handshake");
    check(32'(q), 32'(exp), msg);
  endtask

  task automatic do_reset(input logic m);
    @(posedge clk_sys);
    resetn     <= 1'b0;
    mode_strap <= m;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic t_reset;
    check(32'({prog, awake}), 32'h0, "sleep state after reset");
    check(32'({ack_oe_n, doe_n, wr_en, rd_en}), 32'hc, "port idle after reset");
  endtask

  task automatic t_write_inc;
    wa_q.delete();
    wd_q.delete();
    wr(host_port_pkg::OFS_LOW, 8'hfe);
    wr(host_port_pkg::OFS_HIGH, 8'hb3);
    for (int k = 0; k < 2; k++) begin
      wr(host_port_pkg::OFS_DATA_BYTE_3, 8'hde);
      wr(host_port_pkg::OFS_DATA_BYTE_2, 8'had);
      wr(host_port_pkg::OFS_DATA_BYTE_1, 8'hbe);
      wr(host_port_pkg::OFS_DATA_BYTE_0, 8'(8'hef + k));
    end
    check(wa_q.size(), 2, "internal write count");
    check(wa_q[0], 12'h3fe, "first write address");
    check(wa_q[1], 12'h3ff, "second write address");
    check(wd_q[0], 32'hdeadbeef, "first write data");
    check(wd_q[1], 32'hdeadbef0, "second write data");
    rd(host_port_pkg::OFS_HIGH, 8'h84, "high address after carry");
    rd(host_port_pkg::OFS_LOW, 8'h00, "low address after carry");
  endtask

  task automatic t_read_inc;
    mem[12'h123] = 32'h11223344;
    mem[12'h124] = 32'h55667788;
    wr(host_port_pkg::OFS_HIGH, 8'h41);
    wr(host_port_pkg::OFS_LOW, 8'h23);
    rd(host_port_pkg::OFS_DATA_BYTE_0, 8'h44, "byte 0 of first word");
    rd(host_port_pkg::OFS_DATA_BYTE_3, 8'h11, "byte 3 of first word");
    rd(host_port_pkg::OFS_DATA_BYTE_1, 8'h33, "byte 1 of first word");
    rd(host_port_pkg::OFS_DATA_BYTE_2, 8'h22, "byte 2 of first word");
    rd(host_port_pkg::OFS_DATA_BYTE_0, 8'h88, "byte 0 of next word");
    rd(host_port_pkg::OFS_DATA_BYTE_3, 8'h55, "byte 3 of next word");
    wa_q.delete();
    wr(host_port_pkg::OFS_DATA_BYTE_0, 8'h5a);
    check(wa_q[0], 12'h125, "write address with read increment");
    rd(host_port_pkg::OFS_LOW, 8'h25, "no advance after write");
  endtask

  task automatic t_both_inc;
    mem[12'h011] = 32'h000000a7;
    wr(host_port_pkg::OFS_HIGH, 8'hc0);
    wr(host_port_pkg::OFS_LOW, 8'h10);
    wa_q.delete();
    wr(host_port_pkg::OFS_DATA_BYTE_0, 8'h01);
    rd(host_port_pkg::OFS_DATA_BYTE_0, 8'ha7, "read after advanced write");
    check(wa_q[0], 12'h010, "write address");
    rd(host_port_pkg::OFS_LOW, 8'h12, "advance after both");
  endtask

  task automatic t_sync(input logic [7:0] v, input logic [3:0] eb, input logic [3:0] eh,
                        input logic [3:0] es);
    int b[3][4];
    b = pulse_n;
    wr(host_port_pkg::OFS_SYNC, v);
    for (int c = 0; c < 4; c++) begin
      check(pulse_n[0][c] - b[0][c], 32'(eb[c]), "beam pulses");
      check(pulse_n[1][c] - b[1][c], 32'(eh[c]), "hop pulses");
      check(pulse_n[2][c] - b[2][c], 32'(es[c]), "start pulses");
    end
  endtask

  task automatic t_sleep;
    wr(host_port_pkg::OFS_SLEEP, 8'ha5);
    check(prog, 4'ha, "program bits");
    check(awake, 4'h5, "sleep bits");
    rd(host_port_pkg::OFS_SLEEP, 8'ha5, "sleep readback");
    t_sync(8'h14, 4'h0, 4'h0, 4'h4);
    check(awake, 4'h1, "start clears channel C");
    wr(host_port_pkg::OFS_SLEEP, 8'h0f);
    t_sync(8'h3a, 4'h0, 4'ha, 4'ha);
    check(awake, 4'h5, "start clears B and D");
    t_sync(8'h6f, 4'hf, 4'hf, 4'h0);
    check(awake, 4'h5, "no start keeps sleep bits");
    rd(host_port_pkg::OFS_SYNC, host_port_pkg::SYNC_READ, "sync register read");
    @(posedge clk_sys);
    pin_ss <= 4'h1;
    @(posedge clk_sys);
    pin_ss <= 4'h0;
    repeat (3) @(posedge clk_sys);
    check(awake, 4'h4, "pin start clears channel A");
  endtask

  task automatic t_mode0;
    do_reset(1'b0);
    t_reset();
    mem[12'h041] = 32'hcafe0123;
    wr(host_port_pkg::OFS_HIGH, 8'h80);
    wr(host_port_pkg::OFS_LOW, 8'h40);
    wa_q.delete();
    wd_q.delete();
    wr(host_port_pkg::OFS_DATA_BYTE_3, 8'h01);
    wr(host_port_pkg::OFS_DATA_BYTE_2, 8'h02);
    wr(host_port_pkg::OFS_DATA_BYTE_1, 8'h03);
    wr(host_port_pkg::OFS_DATA_BYTE_0, 8'h04);
    check(wa_q[0], 12'h040, "separate strobe write address");
    check(wd_q[0], 32'h01020304, "separate strobe write data");
    rd(host_port_pkg::OFS_DATA_BYTE_0, 8'h23, "separate strobe read");
    rd(host_port_pkg::OFS_DATA_BYTE_3, 8'hca, "separate strobe byte 3");
  endtask

  initial begin
    resetn     = 1'b0;
    mode_strap = 1'b1;
    pin_ss     = 4'h0;
    run_len    = 0;
    do_reset(1'b1);
    t_reset();
    t_write_inc();
    t_read_inc();
    t_both_inc();
    t_sleep();
    t_mode0();
    conclude();
  end

  // Whole run needs about 500 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire
